// [rx_cfg_defs.vh]
// Register map, field positions, reset values and encodings of the receiver configuration block
`ifndef RX_CFG_DEFS_VH
`define RX_CFG_DEFS_VH

// Register indices; the bus byte address is four times the index
`define IDX_DEMOD_CONTROL       8'h19
`define IDX_SYNC_AND_MIN_LENGTH 8'h1a
`define IDX_MAX_LENGTH_AND_SLOT 8'h1b

`define RST_DEMOD_CONTROL       8'h4d
`define RST_SYNC_AND_MIN_LENGTH 8'h00
`define RST_MAX_LENGTH_AND_SLOT 8'h00

// demod_control fields
`define F_IQ_USE_HI    7
`define F_IQ_USE_LO    6
`define F_CHANNEL_FIX  5
`define F_PRESCALE_EV  4
`define F_TAU_RCV_HI   3
`define F_TAU_RCV_LO   2

// sync_and_min_length fields
`define F_SYNC_LEN_HI  7
`define F_SYNC_LEN_LO  6
`define F_LEN_HI       5
`define F_LEN_LO       0

// max_length_and_slot fields
`define F_WAIT_SEL     7
`define F_SHORT_SLOT   6

// Encodings
`define IQ_STRONGER      2'h0
`define IQ_STRONGER_HOLD 2'h1
`define IQ_COMBINE       2'h2
`define TAU_PLL_FREEZE   2'h0
`define SYNC_BASE_BYTES  3'h2
`define SYNC_WORD        16'hb24d
`define LEN_MAX_DEFAULT  9'h100

`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

// [timer_tick_gen.v]
// Timer prescaler producing one tick per odd or even number of carrier clocks
`timescale 1ns/1ps
module timer_tick_gen #(
    parameter PW = 12
) (
    input  wire          clk_sys,
    input  wire          nrst,
    input  wire [PW-1:0] prescale,
    input  wire          even,
    output reg           tick
);
    reg  [PW+1:0] cnt;
    wire [PW+1:0] last;

    // Period is 2*p+1 or 2*p+2 clocks, so the last count is 2*p or 2*p+1
    assign last = {1'b0, prescale, even};

    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cnt  <= {(PW+2){1'b0}};
            tick <= 1'b0;
        end else if (cnt >= last) begin
            cnt  <= {(PW+2){1'b0}};
            tick <= 1'b1;
        end else begin
            cnt  <= cnt + {{(PW+1){1'b0}}, 1'b1};
            tick <= 1'b0;
        end
    end
endmodule

// [packet_length_filter.v]
// Accept or reject a finished receive packet against the minimum and maximum length fields
`timescale 1ns/1ps
`include "rx_cfg_defs.vh"
module packet_length_filter (
    input  wire       clk_sys,
    input  wire       nrst,
    input  wire       pkt_end,
    input  wire [8:0] pkt_len,
    input  wire [5:0] min_len,
    input  wire [5:0] max_len,
    input  wire       checks_on,
    output reg        pkt_accept,
    output reg        pkt_reject
);
    wire [8:0] min_bytes;
    wire [8:0] max_bytes;
    wire       too_short;
    wire       too_long;
    wire       bad;

    assign min_bytes = {1'b0, min_len, 2'b00};
    assign max_bytes = (max_len == 6'h00) ? `LEN_MAX_DEFAULT : {1'b0, max_len, 2'b00};
    assign too_short = pkt_len < min_bytes;
    assign too_long  = pkt_len > max_bytes;
    assign bad       = checks_on & (too_short | too_long);

    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pkt_accept <= 1'b0;
            pkt_reject <= 1'b0;
        end else begin
            pkt_accept <= pkt_end & ~bad;
            pkt_reject <= pkt_end & bad;
        end
    end
endmodule

// [rx_demod_frame_filter_cfg.v]
// Receiver demodulator, sync and packet length configuration with an AXI4-Lite register port
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "rx_cfg_defs.vh"
module rx_demod_frame_filter_cfg #(
    parameter AW = 8,
    parameter PW = 12
) (
    input  wire          clk_sys,
    input  wire          nrst,
    input  wire [AW-1:0] s_axi_awaddr,
    input  wire [2:0]    s_axi_awprot,
    input  wire          s_axi_awvalid,
    output reg           s_axi_awready,
    input  wire [31:0]   s_axi_wdata,
    input  wire [3:0]    s_axi_wstrb,
    input  wire          s_axi_wvalid,
    output reg           s_axi_wready,
    output reg  [1:0]    s_axi_bresp,
    output reg           s_axi_bvalid,
    input  wire          s_axi_bready,
    input  wire [AW-1:0] s_axi_araddr,
    input  wire [2:0]    s_axi_arprot,
    input  wire          s_axi_arvalid,
    output reg           s_axi_arready,
    output reg  [31:0]   s_axi_rdata,
    output reg  [1:0]    s_axi_rresp,
    output reg           s_axi_rvalid,
    input  wire          s_axi_rready,
    input  wire          rx_active,
    input  wire [PW-1:0] timer_prescale_value,
    input  wire          rate_106,
    input  wire          rate_424,
    input  wire          passive_mode,
    input  wire          sync_detect_enable,
    input  wire          pkt_end,
    input  wire [8:0]    pkt_len,
    input  wire          autocoll_start,
    input  wire          autocoll_abort,
    input  wire          selection_done,
    input  wire          valid_cmd,
    input  wire          active_mode_request,
    output reg           iq_use_i,
    output reg           iq_use_q,
    output reg           iq_combine,
    output reg           iq_pick_stronger,
    output reg           iq_hold_choice,
    output reg  [1:0]    receive_time_constant,
    output reg           pll_freeze,
    output reg  [2:0]    sync_length_bytes,
    output reg  [15:0]   sync_word,
    output wire          timer_tick,
    output wire          pkt_accept,
    output wire          pkt_reject,
    output reg           autocoll_done,
    output reg           active_mode_allowed,
    output reg           slot_half
);
    localparam ST_IDLE = 3'b001;
    localparam ST_HUNT = 3'b010;
    localparam ST_SEL  = 3'b100;

    reg  [7:0]    demod_control;
    reg  [7:0]    sync_and_min_length;
    reg  [7:0]    max_length_and_slot;

    reg           aw_held;
    reg           w_held;
    reg  [AW-1:0] waddr;
    reg  [7:0]    wbyte;
    reg           wlane;
    reg  [2:0]    ac_state;
    reg  [2:0]    next_ac_state;
    reg           next_done;
    reg  [7:0]    rd_byte;
    reg           rd_hit;
    reg           wr_hit;

    wire [1:0]    iq_use_select;
    wire          channel_fix;
    wire          prescale_even;
    wire [1:0]    sync_length_select;
    wire [5:0]    min_packet_length;
    wire [5:0]    max_packet_length;
    wire          wait_for_selection;
    wire          short_slot_select;
    wire          checks_on;
    wire [AW-1:0] idx_w;
    wire [AW-1:0] idx_r;

    assign iq_use_select      = demod_control[`F_IQ_USE_HI:`F_IQ_USE_LO];
    assign channel_fix        = demod_control[`F_CHANNEL_FIX];
    assign prescale_even      = demod_control[`F_PRESCALE_EV];
    assign sync_length_select = sync_and_min_length[`F_SYNC_LEN_HI:`F_SYNC_LEN_LO];
    assign min_packet_length  = sync_and_min_length[`F_LEN_HI:`F_LEN_LO];
    assign max_packet_length  = max_length_and_slot[`F_LEN_HI:`F_LEN_LO];
    assign wait_for_selection = max_length_and_slot[`F_WAIT_SEL];
    assign short_slot_select  = max_length_and_slot[`F_SHORT_SLOT];
    assign checks_on          = ~(rate_106 & ~sync_detect_enable);

    // Word addressing: the low two address bits are ignored
    assign idx_w = {2'b00, waddr[AW-1:2]};
    assign idx_r = {2'b00, s_axi_araddr[AW-1:2]};

    // Write decode
    always @* begin
        case (idx_w)
            `IDX_DEMOD_CONTROL:       wr_hit = 1'b1;
            `IDX_SYNC_AND_MIN_LENGTH: wr_hit = 1'b1;
            `IDX_MAX_LENGTH_AND_SLOT: wr_hit = 1'b1;
            default:                  wr_hit = 1'b0;
        endcase
    end

    // Read decode; unmapped words read zero with an error response
    always @* begin
        rd_hit  = 1'b1;
        rd_byte = 8'h00;
        case (idx_r)
            `IDX_DEMOD_CONTROL:       rd_byte = demod_control;
            `IDX_SYNC_AND_MIN_LENGTH: rd_byte = sync_and_min_length;
            `IDX_MAX_LENGTH_AND_SLOT: rd_byte = max_length_and_slot;
            default:                  rd_hit  = 1'b0;
        endcase
    end

    // Write channel: address and data taken in either order, one write in flight
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            s_axi_awready       <= 1'b1;
            s_axi_wready        <= 1'b1;
            s_axi_bvalid        <= 1'b0;
            s_axi_bresp         <= `RESP_OKAY;
            aw_held             <= 1'b0;
            w_held              <= 1'b0;
            waddr               <= {AW{1'b0}};
            wbyte               <= 8'h00;
            wlane               <= 1'b0;
            demod_control       <= `RST_DEMOD_CONTROL;
            sync_and_min_length <= `RST_SYNC_AND_MIN_LENGTH;
            max_length_and_slot <= `RST_MAX_LENGTH_AND_SLOT;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held       <= 1'b1;
                waddr         <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held       <= 1'b1;
                wbyte        <= s_axi_wdata[7:0];
                wlane        <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            if (aw_held && w_held && !s_axi_bvalid) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
                // Only byte lane 0 holds register bits; other lanes are dropped
                if (wlane) begin
                    case (idx_w)
                        `IDX_DEMOD_CONTROL:       demod_control       <= wbyte;
                        `IDX_SYNC_AND_MIN_LENGTH: sync_and_min_length <= wbyte;
                        `IDX_MAX_LENGTH_AND_SLOT: max_length_and_slot <= wbyte;
                        default: ;
                    endcase
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Read channel: data one cycle after the address is taken
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= {24'h000000, rd_byte};
                s_axi_rresp   <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // Receive path steering
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            iq_use_i              <= 1'b0;
            iq_use_q              <= 1'b0;
            iq_combine            <= 1'b0;
            iq_pick_stronger      <= 1'b0;
            iq_hold_choice        <= 1'b0;
            receive_time_constant <= 2'h0;
            pll_freeze            <= 1'b0;
            sync_length_bytes     <= `SYNC_BASE_BYTES;
            sync_word             <= `SYNC_WORD;
            active_mode_allowed   <= 1'b0;
            slot_half             <= 1'b0;
        end else begin
            // Fixed channel overrides the I/Q field modes; field bit 0 then selects I or Q
            iq_use_i         <= channel_fix & ~iq_use_select[0];
            iq_use_q         <= channel_fix & iq_use_select[0];
            iq_combine       <= ~channel_fix & (iq_use_select == `IQ_COMBINE);
            // Reserved code falls back to picking the stronger channel
            iq_pick_stronger <= ~channel_fix & (iq_use_select != `IQ_COMBINE);
            iq_hold_choice   <= ~channel_fix & (iq_use_select == `IQ_STRONGER_HOLD);
            receive_time_constant <= demod_control[`F_TAU_RCV_HI:`F_TAU_RCV_LO];
            pll_freeze <= rx_active &
                          (demod_control[`F_TAU_RCV_HI:`F_TAU_RCV_LO] == `TAU_PLL_FREEZE);
            sync_length_bytes   <= `SYNC_BASE_BYTES + {1'b0, sync_length_select};
            sync_word           <= `SYNC_WORD;
            active_mode_allowed <= active_mode_request & ~wait_for_selection;
            slot_half           <= passive_mode & rate_424 & short_slot_select;
        end
    end

    // Automatic anticollision termination
    always @* begin
        next_ac_state = ac_state;
        next_done     = 1'b0;
        case (ac_state)
            ST_IDLE: begin
                if (autocoll_start) begin
                    next_ac_state = ST_HUNT;
                end
            end
            ST_HUNT: begin
                if (autocoll_abort) begin
                    next_ac_state = ST_IDLE;
                end else if (!wait_for_selection && valid_cmd) begin
                    next_ac_state = ST_IDLE;
                    next_done     = 1'b1;
                end else if (wait_for_selection && selection_done) begin
                    next_ac_state = ST_SEL;
                end
            end
            ST_SEL: begin
                if (autocoll_abort) begin
                    next_ac_state = ST_IDLE;
                end else if (valid_cmd) begin
                    next_ac_state = ST_IDLE;
                    next_done     = 1'b1;
                end
            end
            default: begin
                next_ac_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ac_state      <= ST_IDLE;
            autocoll_done <= 1'b0;
        end else begin
            ac_state      <= next_ac_state;
            autocoll_done <= next_done;
        end
    end

    // Both helpers register their outputs, so these stay flop-driven
    timer_tick_gen #(
        .PW (PW)
    ) u_timer (
        .clk_sys  (clk_sys),
        .nrst     (nrst),
        .prescale (timer_prescale_value),
        .even     (prescale_even),
        .tick     (timer_tick)
    );

    packet_length_filter u_filter (
        .clk_sys    (clk_sys),
        .nrst       (nrst),
        .pkt_end    (pkt_end),
        .pkt_len    (pkt_len),
        .min_len    (min_packet_length),
        .max_len    (max_packet_length),
        .checks_on  (checks_on),
        .pkt_accept (pkt_accept),
        .pkt_reject (pkt_reject)
    );
endmodule

// [rx_cfg_chk.sv]
// Port-level assertions of the receiver configuration block
`timescale 1ns/1ps
module rx_cfg_chk (
    input logic        clk_sys,
    input logic        nrst,
    input logic        pkt_end,
    input logic [8:0]  pkt_len,
    input logic        rate_106,
    input logic        sync_detect_enable,
    input logic        pkt_accept,
    input logic        pkt_reject,
    input logic        rx_active,
    input logic        pll_freeze,
    input logic        active_mode_request,
    input logic        active_mode_allowed,
    input logic        passive_mode,
    input logic        rate_424,
    input logic        slot_half,
    input logic        iq_use_i,
    input logic        iq_use_q,
    input logic        iq_combine,
    input logic        iq_pick_stronger,
    input logic [2:0]  sync_length_bytes,
    input logic [15:0] sync_word,
    input logic        valid_cmd,
    input logic        autocoll_done
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // Packet lengths above 256 never pass while the length checks are on, whatever the maximum field holds
    AST_PKT_ONE: assert property (pkt_end |=> pkt_accept != pkt_reject)
        else $error("packet verdict is not exactly one pulse");
    AST_PKT_IDLE: assert property (!pkt_end |=> !pkt_accept && !pkt_reject)
        else $error("packet verdict without packet end");
    AST_PKT_SKIP: assert property (pkt_end && rate_106 && !sync_detect_enable |=> pkt_accept)
        else $error("length check not skipped");
    AST_PKT_LONG: assert property (
        pkt_end && pkt_len > 9'h100 && !(rate_106 && !sync_detect_enable) |=> pkt_reject)
        else $error("overlong packet accepted");
    AST_PLL: assert property (!rx_active |=> !pll_freeze)
        else $error("pll frozen outside reception");
    AST_ACTIVE: assert property (!active_mode_request |=> !active_mode_allowed)
        else $error("active mode allowed without request");
    AST_SLOT: assert property (!(passive_mode && rate_424) |=> !slot_half)
        else $error("short slot outside passive 424");
    AST_IQ: assert property (iq_combine |-> !iq_pick_stronger && !iq_use_i && !iq_use_q)
        else $error("combine mixed with another channel mode");
    AST_FIX: assert property (
        iq_use_i || iq_use_q |-> !(iq_use_i && iq_use_q) && !iq_pick_stronger && !iq_combine)
        else $error("fixed channel decode broken");
    AST_SYNC: assert property (
        sync_word == 16'hb24d && sync_length_bytes >= 3'h2 && sync_length_bytes <= 3'h5)
        else $error("sync pattern out of range");
    AST_DONE: assert property (autocoll_done |-> $past(valid_cmd) ##1 !autocoll_done)
        else $error("autocoll end without command");
endmodule
bind rx_demod_frame_filter_cfg rx_cfg_chk chk (.*);

// [host_bus_model.sv]
// AXI4-Lite host model playing the software side of the register port
`timescale 1ns/1ps
module host_bus_model (
    input  logic        clk_sys,
    output logic [7:0]  s_axi_awaddr,
    output logic [2:0]  s_axi_awprot,
    output logic        s_axi_awvalid,
    input  logic        s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0]  s_axi_wstrb,
    output logic        s_axi_wvalid,
    input  logic        s_axi_wready,
    input  logic [1:0]  s_axi_bresp,
    input  logic        s_axi_bvalid,
    output logic        s_axi_bready,
    output logic [7:0]  s_axi_araddr,
    output logic [2:0]  s_axi_arprot,
    output logic        s_axi_arvalid,
    input  logic        s_axi_arready,
    input  logic [31:0] s_axi_rdata,
    input  logic [1:0]  s_axi_rresp,
    input  logic        s_axi_rvalid,
    output logic        s_axi_rready
);
    initial begin
        {s_axi_awaddr, s_axi_awprot, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_araddr, s_axi_arprot, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hf;
    end
    // Released payload is inverted so a slave latching late sees garbage
    task wr(input logic [7:0] a, input logic [7:0] v, input logic [3:0] s, output logic [1:0] r);
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, v};
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr <= ~a;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~s_axi_wdata;
            end
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arvalid <= 1'b0;
                s_axi_araddr <= ~a;
            end
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
endmodule

// [rx_demod_frame_filter_cfg_tb.sv]
// Self-checking testbench of the receiver configuration block
`timescale 1ns/1ps
module rx_demod_frame_filter_cfg_tb;
    logic clk_sys = 0, nrst = 0, rx_active = 0, rate_106 = 0, rate_424 = 0, passive_mode = 0;
    logic sync_detect_enable = 0, pkt_end = 0, autocoll_start = 0, autocoll_abort = 0;
    logic selection_done = 0, valid_cmd = 0, active_mode_request = 0;
    logic [11:0] timer_prescale_value = 12'h003;
    logic [8:0]  pkt_len = 9'h000;
    wire [7:0]   s_axi_awaddr, s_axi_araddr;
    wire [31:0]  s_axi_wdata, s_axi_rdata;
    wire [2:0]   s_axi_awprot, s_axi_arprot, sync_length_bytes;
    wire [3:0]   s_axi_wstrb;
    wire [1:0]   s_axi_bresp, s_axi_rresp, receive_time_constant;
    wire         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    wire         s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, timer_tick, pll_freeze;
    wire         iq_use_i, iq_use_q, iq_combine, iq_pick_stronger, iq_hold_choice, slot_half;
    wire         pkt_accept, pkt_reject, autocoll_done, active_mode_allowed;
    wire [15:0]  sync_word;
    int          bad_count = 0, checked = 0, n, k;
    logic [31:0] d;
    logic [1:0]  r;
    rx_demod_frame_filter_cfg dut (.*);
    host_bus_model host (.*);
    always #4 clk_sys = ~clk_sys;
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    // Two spare edges let the static outputs follow the new register value
    task wr(input logic [7:0] a, input logic [7:0] v, input logic [1:0] er);
        host.wr(a, v, 4'hf, r);
        chk(r, er);
        repeat (2) @(posedge clk_sys);
    endtask
    task rd(input logic [7:0] a, input logic [7:0] v, input logic [1:0] er);
        host.rd(a, d, r);
        chk(d, v);
        chk(r, er);
    endtask
    task pkt(input logic [8:0] len, input logic acc);
        @(posedge clk_sys);
        pkt_end <= 1'b1;
        pkt_len <= len;
        @(posedge clk_sys);
        pkt_end <= 1'b0;
        @(posedge clk_sys);
        chk({pkt_accept, pkt_reject}, {acc, ~acc});
    endtask
    // First interval after a write may mix old and new settings, so skip it
    task period(input logic [7:0] v, input int exp);
        wr(8'h64, v, 2'h0);
        repeat (2) do @(posedge clk_sys); while (!timer_tick);
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (!timer_tick && n < 50);
        chk(n, exp);
    endtask
    task tend(input string s);
        $display("test %s done, %0d checks", s, checked);
    endtask
    task test_done;
        $display("checks %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk_sys);
        nrst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        chk({iq_pick_stronger, iq_hold_choice}, 2'b11);
        rd(8'h64, 8'h4d, 2'h0);
        rd(8'h68, 8'h00, 2'h0);
        rd(8'h6c, 8'h00, 2'h0);
        rd(8'h70, 8'h00, 2'h2);
        wr(8'h70, 8'hff, 2'h2);
        wr(8'h68, 8'hff, 2'h0);
        rd(8'h68, 8'hff, 2'h0);
        // Lane 0 strobe low: answered OKAY but nothing is stored
        host.wr(8'h68, 8'h55, 4'he, r);
        chk(r, 2'h0);
        rd(8'h68, 8'hff, 2'h0);
        tend("registers");
        for (k = 0; k < 8; k++) begin
            wr(8'h64, {k[2:0], 5'h0c}, 2'h0);
            rd(8'h64, {k[2:0], 5'h0c}, 2'h0);
            chk({iq_use_i, iq_use_q, iq_combine, iq_pick_stronger, iq_hold_choice},
                k[0] ? {~k[1], k[1], 3'h0} : k[2:1] == 2'h2 ? 5'h04 : {4'h1, k[2:1] == 2'h1});
        end
        tend("channel");
        wr(8'h64, 8'h41, 2'h0);
        rx_active <= 1'b1;
        repeat (2) @(posedge clk_sys);
        chk({pll_freeze, receive_time_constant}, 3'h4);
        rx_active <= 1'b0;
        repeat (2) @(posedge clk_sys);
        chk(pll_freeze, 1'b0);
        for (k = 0; k < 4; k++) begin
            wr(8'h68, {k[1:0], 6'h00}, 2'h0);
            chk({sync_length_bytes, sync_word}, {3'h2 + k[2:0], 16'hb24d});
        end
        period(8'h4d, 7);
        period(8'h5d, 8);
        timer_prescale_value <= 12'h000;
        period(8'h4d, 1);
        period(8'h5d, 2);
        tend("pll sync timer");
        wr(8'h68, 8'h02, 2'h0);
        wr(8'h6c, 8'h03, 2'h0);
        pkt(9'h007, 1'b0);
        pkt(9'h008, 1'b1);
        pkt(9'h00c, 1'b1);
        pkt(9'h00d, 1'b0);
        wr(8'h6c, 8'h00, 2'h0);
        pkt(9'h100, 1'b1);
        pkt(9'h101, 1'b0);
        rate_106 <= 1'b1;
        pkt(9'h007, 1'b1);
        sync_detect_enable <= 1'b1;
        pkt(9'h007, 1'b0);
        tend("length");
        wr(8'h6c, 8'h80, 2'h0);
        autocoll_start <= 1'b1;
        active_mode_request <= 1'b1;
        @(posedge clk_sys);
        autocoll_start <= 1'b0;
        valid_cmd <= 1'b1;
        @(posedge clk_sys);
        valid_cmd <= 1'b0;
        selection_done <= 1'b1;
        @(posedge clk_sys);
        chk(autocoll_done, 1'b0);
        selection_done <= 1'b0;
        valid_cmd <= 1'b1;
        @(posedge clk_sys);
        valid_cmd <= 1'b0;
        chk(active_mode_allowed, 1'b0);
        @(posedge clk_sys);
        chk(autocoll_done, 1'b1);
        wr(8'h6c, 8'h40, 2'h0);
        chk(active_mode_allowed, 1'b1);
        autocoll_start <= 1'b1;
        passive_mode <= 1'b1;
        rate_424 <= 1'b1;
        @(posedge clk_sys);
        autocoll_start <= 1'b0;
        valid_cmd <= 1'b1;
        @(posedge clk_sys);
        valid_cmd <= 1'b0;
        @(posedge clk_sys);
        chk({autocoll_done, slot_half}, 2'b11);
        rate_424 <= 1'b0;
        repeat (2) @(posedge clk_sys);
        chk(slot_half, 1'b0);
        // Abort drops back to idle, so a later command must not end anything
        autocoll_start <= 1'b1;
        @(posedge clk_sys);
        autocoll_start <= 1'b0;
        autocoll_abort <= 1'b1;
        @(posedge clk_sys);
        autocoll_abort <= 1'b0;
        valid_cmd <= 1'b1;
        @(posedge clk_sys);
        valid_cmd <= 1'b0;
        @(posedge clk_sys);
        chk(autocoll_done, 1'b0);
        tend("control");
        test_done;
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        bad_count++;
        test_done;
    end
endmodule
